// ---- iocr_cfg.svh ----
// offsets, field positions, reset values and timing counts of the io and operation control bank
`ifndef IOCR_CFG_SVH
`define IOCR_CFG_SVH

// word indices on the bus, four bits wide like the address; byte address = 4 * index
`define IOCR_IDX_OPCTL        4'h2
`define IOCR_IDX_IOCFG2       4'h1
`define IOCR_IDX_RXCFG        4'ha
`define IOCR_IDX_STATUS       4'hb

// interface configuration fields
`define IOCR_IOCFG_LOWSUP     7
`define IOCR_IOCFG_DIGOFF     6
`define IOCR_IOCFG_PDSEL      4
`define IOCR_IOCFG_PDDES      3
`define IOCR_IOCFG_BOOST      2
`define IOCR_IOCFG_RAMP       0
`define IOCR_IOCFG_MASK       8'hdd

// operation control fields
`define IOCR_OPCTL_EN         7
`define IOCR_OPCTL_RXEN       6
`define IOCR_OPCTL_RXONE      5
`define IOCR_OPCTL_RXMAN      4
`define IOCR_OPCTL_TXEN       3
`define IOCR_OPCTL_WU         2
`define IOCR_OPCTL_MASK       8'hfc

// receiver configuration: channel pick
`define IOCR_RXCFG_PICK       0
`define IOCR_RXCFG_MASK       8'h01

`define IOCR_RESET_VAL        8'h00

// transmitter slow ramp: least 10 us, at 10 MHz
`define IOCR_RAMP_NS          10000
`define IOCR_CLK_NS           100
`define IOCR_RAMP_CYC         ((`IOCR_RAMP_NS + `IOCR_CLK_NS - 1) / `IOCR_CLK_NS)

`endif

// ---- iocr_pkg.sv ----
// types of the io and operation control bank
package iocr_pkg;

  // avalon-mm request from the master
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } iocr_req_t;

  // avalon-mm answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } iocr_rsp_t;

  // transmitter ramp states, gray along off -> ramp -> on
  typedef enum logic [1:0] {
    IOCR_TX_OFF  = 2'b00,
    IOCR_TX_RAMP = 2'b01,
    IOCR_TX_ON   = 2'b11
  } iocr_tx_t;

endpackage : iocr_pkg

// ---- iocr_tx_ramp.sv ----
// transmitter ramp sequencer: fast or slow turn-on of the driver
`include "iocr_cfg.svh"
`timescale 1ns/1ps
module iocr_tx_ramp #(
  parameter int RAMP_CYC = `IOCR_RAMP_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              tx_on,
  input  wire logic              slow,
  output iocr_pkg::iocr_tx_t     state,
  output logic                   tx_full
);
  import iocr_pkg::*;

  initial begin
    if (RAMP_CYC < 1 || RAMP_CYC > 65535) $error("iocr_tx_ramp: RAMP_CYC out of range");
  end

  iocr_tx_t    state_reg;
  iocr_tx_t    state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  wire         ramp_done = (cnt_reg == 16'(RAMP_CYC - 1));

  // next state: slow mode holds the ramp for the full count before full drive
  always_comb begin
    state_next = state_reg;
    cnt_next   = 16'h0000;
    case (state_reg)
      IOCR_TX_OFF: begin
        if (tx_on) state_next = slow ? IOCR_TX_RAMP : IOCR_TX_ON;
      end
      IOCR_TX_RAMP: begin
        cnt_next = cnt_reg + 16'h0001;
        if (!tx_on) state_next = IOCR_TX_OFF;
        else if (ramp_done) state_next = IOCR_TX_ON;
      end
      IOCR_TX_ON: begin
        if (!tx_on) state_next = IOCR_TX_OFF;
      end
      default: state_next = IOCR_TX_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= IOCR_TX_OFF;
      cnt_reg   <= 16'h0000;
      tx_full   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      tx_full   <= (state_next == IOCR_TX_ON);
    end
  end

  assign state = state_reg;

endmodule : iocr_tx_ramp

// ---- iocr_regs.sv ----
// io configuration and operation control register bank with avalon-mm slave
//
// Function
// - interface bit 7 picks 5 V supply when clear, 3.3 V when set.
// - interface bit 6 set switches off the digital supply regulator.
// - bit 4 pulls data-out low while selected and not driven.
// - bit 3 pulls data-out low whenever slave select is high.
// - bit 2 raises data-out drive strength for 1.8 V io.
// - bit 0 ramps transmitter slowly, at least 10 us.
// - both registers load zero at power-up only; commands do not reset them.
// - control bit 7 turns on oscillator and regulator, ready mode.
// - control bit 6 enables reception.
// - control bit 5 clear enables both channels, set only one.
// - single channel is chosen by the channel pick bit.
// - both channels: bit 4 clear automatic, set manual via channel pick.
// - control bit 3 enables transmission.
// - field-on command sets transmit enable by itself.
// - active peer mode clears transmit enable after transmission ends.
// - control bit 2 enables wake-up mode per wake-up timer settings.
//
// register map, word index on the bus (byte address is four times the index):
//   0x01  interface configuration: supply, regulator, pull-downs, boost, ramp
//   0x02  operation control: enables, channel policy, wake-up
//   0x0a  receiver configuration: channel pick in bit 0 (1 = phase channel)
//   0x0b  status, read only: synced select, synced drive, transmitter state
// any other index answers with a slave error; writes there are dropped.
//
// bus timing: a request is taken on the edge where it is first seen, the
// register changes on that edge and waitrequest drops for the next cycle,
// so every access costs exactly one wait state. read data and the response
// code are registered and stand only in the cycle with waitrequest low.
// a master that keeps its request up after that cycle starts a new access.
// only byte lane 0 carries data; a write with that lane disabled is dropped.
//
// transmit enable has three writers: software, the field-on command and the
// end of an active peer transmission. the command wins over both clears, so
// a field-on in the cycle of a software clear still leaves the transmitter on.
//
// transmitter and receiver run only while the oscillator enable is set;
// clearing it drops both within two cycles whatever their own bits say.
//
// select and drive arrive from pins and pass two flops each, so the
// pull-down output lags a pin change by three clock cycles in all.
// defaults load only on reset: no command path reloads the registers.
//
// limitation: the analog effect of each option lives outside this bank;
// the outputs here are plain levels for the pad ring and the front end.
`include "iocr_cfg.svh"
`timescale 1ns/1ps
module iocr_regs #(
  parameter int RAMP_CYC = `IOCR_RAMP_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  iocr_pkg::iocr_req_t    avs_req,
  output iocr_pkg::iocr_rsp_t    avs_rsp,
  input  wire logic              slave_select_n,
  input  wire logic              data_out_driven,
  input  wire logic              field_on_cmd,
  input  wire logic              active_peer_mode,
  input  wire logic              tx_finished,
  input  wire logic              auto_ch_amplitude,
  output logic                   low_supply_select,
  output logic                   digital_supply_rail_off,
  output logic                   data_out_pulldown,
  output logic                   data_out_boost,
  output logic                   osc_reg_enable,
  output logic                   rx_enable,
  output logic                   rx_amp_ch_on,
  output logic                   rx_phase_ch_on,
  output logic                   rx_use_amplitude,
  output logic                   tx_enable,
  output logic                   tx_slow_ramping,
  output logic                   wakeup_mode_on
);
  import iocr_pkg::*;

  // the masks must cover exactly the defined fields, else a field would be lost
  localparam logic [7:0] IO_FIELDS = (8'h01 << `IOCR_IOCFG_LOWSUP) | (8'h01 << `IOCR_IOCFG_DIGOFF) |
                                     (8'h01 << `IOCR_IOCFG_PDSEL)  | (8'h01 << `IOCR_IOCFG_PDDES)  |
                                     (8'h01 << `IOCR_IOCFG_BOOST)  | (8'h01 << `IOCR_IOCFG_RAMP);
  localparam logic [7:0] OP_FIELDS = (8'h01 << `IOCR_OPCTL_EN)     | (8'h01 << `IOCR_OPCTL_RXEN)   |
                                     (8'h01 << `IOCR_OPCTL_RXONE)  | (8'h01 << `IOCR_OPCTL_RXMAN)  |
                                     (8'h01 << `IOCR_OPCTL_TXEN)   | (8'h01 << `IOCR_OPCTL_WU);

  // elaboration checks; the ramp counter is sixteen bits wide
  initial begin
    if (RAMP_CYC < 1) $error("iocr_regs: RAMP_CYC must be at least one");
    if (RAMP_CYC > 65535) $error("iocr_regs: RAMP_CYC exceeds the ramp counter");
    if (IO_FIELDS != `IOCR_IOCFG_MASK) $error("iocr_regs: interface mask disagrees with fields");
    if (OP_FIELDS != `IOCR_OPCTL_MASK) $error("iocr_regs: control mask disagrees with fields");
  end

  // pin inputs pass two flops; stage one is read only by stage two
  // bit 0 is slave select, idle high; bit 1 is the data-out drive flag, idle low
  localparam int         NPIN     = 2;
  localparam logic [1:0] PIN_IDLE = 2'b01;

  wire  [NPIN-1:0] pin_raw = {data_out_driven, slave_select_n};
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;

  // one chain per pin; reset to the idle level so no false edge follows reset
  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (reset) begin
        pin_meta_reg[gi] <= PIN_IDLE[gi];
        pin_sync_reg[gi] <= PIN_IDLE[gi];
      end else begin
        pin_meta_reg[gi] <= pin_raw[gi];
        pin_sync_reg[gi] <= pin_meta_reg[gi];
      end
    end
  end

  // synced views used by the decode and the status word
  wire ss_sync_reg  = pin_sync_reg[0];
  wire drv_sync_reg = pin_sync_reg[1];

  // register storage
  logic [7:0] iocfg_reg;
  logic [7:0] iocfg_next;
  logic [7:0] opctl_reg;
  logic [7:0] opctl_next;
  logic [7:0] rxcfg_reg;
  logic [7:0] rxcfg_next;

  // bus handshake: one wait cycle, then the answer; keeps readdata registered
  // waitrequest is a flop of its own so the bus outputs all come from registers
  logic        ack_reg;
  logic        wreq_reg;
  logic [31:0] rdata_reg;
  logic        err_reg;

  wire        req_any   = avs_req.read | avs_req.write;
  wire        do_access = req_any & ~ack_reg;
  wire        be_low    = avs_req.byteenable[0];
  wire        hit_io    = (avs_req.address == `IOCR_IDX_IOCFG2);
  wire        hit_op    = (avs_req.address == `IOCR_IDX_OPCTL);
  wire        hit_rx    = (avs_req.address == `IOCR_IDX_RXCFG);
  wire        hit_st    = (avs_req.address == `IOCR_IDX_STATUS);
  wire        mapped    = hit_io | hit_op | hit_rx | hit_st;
  wire        wr_en     = do_access & avs_req.write & be_low;
  wire        wr_io     = wr_en & hit_io;
  wire        wr_op     = wr_en & hit_op;
  wire        wr_rx     = wr_en & hit_rx;
  wire [7:0]  wdata     = avs_req.writedata[7:0];

  // tx enable: hardware set by field-on wins over a software clear,
  // hardware clear after an active-peer transmission
  // the set winning matters when a host clear and a field-on meet in one
  // cycle: losing the command would leave the field off with no error shown
  wire        tx_hw_set = field_on_cmd;
  wire        tx_hw_clr = active_peer_mode & tx_finished;
  wire        tx_sw_val = wr_op ? wdata[`IOCR_OPCTL_TXEN] : opctl_reg[`IOCR_OPCTL_TXEN];
  wire        tx_new    = tx_hw_set | (tx_sw_val & ~tx_hw_clr);

  // next register values, unused bits masked to zero
  assign iocfg_next = wr_io ? (wdata & `IOCR_IOCFG_MASK) : iocfg_reg;
  assign rxcfg_next = wr_rx ? (wdata & `IOCR_RXCFG_MASK) : rxcfg_reg;
  assign opctl_next = {(wr_op ? wdata[7:4] : opctl_reg[7:4]),
                       tx_new,
                       (wr_op ? wdata[`IOCR_OPCTL_WU] : opctl_reg[`IOCR_OPCTL_WU]),
                       2'b00};

  // status view of the block's own state
  iocr_tx_t   tx_state;
  logic       tx_full;
  wire [7:0]  status_val = {4'h0, ss_sync_reg, drv_sync_reg, tx_state};

  wire [7:0]  rd_sel = hit_io ? iocfg_reg :
                       hit_op ? opctl_reg :
                       hit_rx ? rxcfg_reg :
                       hit_st ? status_val : 8'h00;

  // registers: zero only at power-up reset, no command reloads them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      iocfg_reg <= `IOCR_RESET_VAL;
      opctl_reg <= `IOCR_RESET_VAL;
      rxcfg_reg <= `IOCR_RESET_VAL;
    end else begin
      iocfg_reg <= iocfg_next;
      opctl_reg <= opctl_next;
      rxcfg_reg <= rxcfg_next;
    end
  end

  // bus answer registers; unmapped address answers with slave error
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      wreq_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      ack_reg   <= do_access;
      wreq_reg  <= ~do_access; // low only in the answer cycle
      rdata_reg <= (do_access & avs_req.read) ? {24'h000000, rd_sel} : 32'h0000_0000;
      err_reg   <= do_access & ~mapped;
    end
  end

  assign avs_rsp.readdata    = rdata_reg;
  assign avs_rsp.waitrequest = wreq_reg;
  assign avs_rsp.response    = err_reg ? 2'b10 : 2'b00;

  // transmitter ramp follows enable and ramp option
  iocr_tx_ramp #(
    .RAMP_CYC (RAMP_CYC)
  ) u_ramp (
    .core_clk (core_clk),
    .reset    (reset),
    .tx_on    (opctl_reg[`IOCR_OPCTL_TXEN] & opctl_reg[`IOCR_OPCTL_EN]),
    .slow     (iocfg_reg[`IOCR_IOCFG_RAMP]),
    .state    (tx_state),
    .tx_full  (tx_full)
  );

  // field views of the stored registers: supply, regulator, boost, enable, wake-up
  wire io_low_supply = iocfg_reg[`IOCR_IOCFG_LOWSUP];
  wire io_dig_off    = iocfg_reg[`IOCR_IOCFG_DIGOFF];
  wire io_boost      = iocfg_reg[`IOCR_IOCFG_BOOST];
  wire op_enable     = opctl_reg[`IOCR_OPCTL_EN];
  wire op_wakeup     = opctl_reg[`IOCR_OPCTL_WU];
  wire tx_ramping    = (tx_state == IOCR_TX_RAMP);

  // pull-down decode from synced select and drive state
  // both options may be set at once; they cover disjoint select levels
  wire pd_sel  = iocfg_reg[`IOCR_IOCFG_PDSEL] & ~ss_sync_reg & ~drv_sync_reg;
  wire pd_des  = iocfg_reg[`IOCR_IOCFG_PDDES] & ss_sync_reg;

  // channel policy: single channel or manual use the pick bit
  // the automatic choice comes from the receiver and is used only when
  // both channels run and manual choice is off
  wire one_ch  = opctl_reg[`IOCR_OPCTL_RXONE];
  wire manual  = opctl_reg[`IOCR_OPCTL_RXMAN];
  wire pick_am = ~rxcfg_reg[`IOCR_RXCFG_PICK];
  wire use_am  = (one_ch | manual) ? pick_am : auto_ch_amplitude;
  wire rx_on   = opctl_reg[`IOCR_OPCTL_RXEN] & opctl_reg[`IOCR_OPCTL_EN];

  // decoded outputs, all registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_supply_select       <= 1'b0;
      digital_supply_rail_off <= 1'b0;
      data_out_pulldown       <= 1'b0;
      data_out_boost          <= 1'b0;
      osc_reg_enable          <= 1'b0;
      rx_enable               <= 1'b0;
      rx_amp_ch_on            <= 1'b0;
      rx_phase_ch_on          <= 1'b0;
      rx_use_amplitude        <= 1'b0;
      tx_enable               <= 1'b0;
      tx_slow_ramping         <= 1'b0;
      wakeup_mode_on          <= 1'b0;
    end else begin
      // supply and pad options
      low_supply_select       <= io_low_supply;
      digital_supply_rail_off <= io_dig_off;
      data_out_pulldown       <= pd_sel | pd_des;
      data_out_boost          <= io_boost;
      // operating enables and receive channels
      osc_reg_enable          <= op_enable;
      rx_enable               <= rx_on;
      rx_amp_ch_on            <= rx_on & (~one_ch | pick_am);
      rx_phase_ch_on          <= rx_on & (~one_ch | ~pick_am);
      rx_use_amplitude        <= use_am;
      // transmitter and wake-up
      tx_enable               <= tx_full | tx_ramping;
      tx_slow_ramping         <= tx_ramping;
      wakeup_mode_on          <= op_wakeup;
    end
  end

endmodule : iocr_regs

// ---- iocr_assertions.sv ----
// checker of bus handshake and control outputs of the io and operation control bank
`timescale 1ns/1ps
module iocr_assertions #(
  parameter int RAMP_CYC = 4
) (
  input wire logic           core_clk,
  input wire logic           reset,
  input iocr_pkg::iocr_req_t avs_req,
  input iocr_pkg::iocr_rsp_t avs_rsp,
  input wire logic           field_on_cmd,
  input wire logic           osc_reg_enable,
  input wire logic           rx_enable,
  input wire logic           tx_enable,
  input wire logic           tx_slow_ramping
);
  import iocr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // request decode; only four word indices answer without error
  wire       rq     = avs_req.read | avs_req.write;
  wire       done   = rq & ~avs_rsp.waitrequest;
  wire [3:0] a      = avs_req.address;
  wire       mapped = a == 4'h1 || a == 4'h2 || a == 4'ha || a == 4'hb;
  int        ramp_cnt;
  // cycles spent in the slow ramp so far
  always_ff @(posedge core_clk) ramp_cnt <= (reset || !tx_slow_ramping) ? 0 : ramp_cnt + 1;
  sequence s_wait; rq && avs_rsp.waitrequest; endsequence
  sequence s_held; s_wait ##1 rq; endsequence
  chk_first_waits: assert property ($rose(rq) |-> s_wait) else $error("new access without wait state");
  chk_one_wait: assert property (s_held |-> !avs_rsp.waitrequest) else $error("more than one wait state");
  chk_unmapped_err: assert property (done && !mapped |-> avs_rsp.response == 2'b10 && avs_rsp.readdata == 32'h0)
    else $error("unmapped access not refused");
  chk_high_zero: assert property (done && avs_req.read |-> avs_rsp.readdata[31:8] == 24'h0) else $error("upper lanes not zero");
  chk_unused_zero: assert property (done && avs_req.read |-> (a != 4'h1 || avs_rsp.readdata[5:0] ==? 6'b0???0?)
    && (a != 4'h2 || avs_rsp.readdata[1:0] == 2'b00)) else $error("unused bit reads one");
  chk_rx_needs_osc: assert property (rx_enable |-> osc_reg_enable) else $error("rx on without oscillator");
  chk_tx_needs_osc: assert property (!osc_reg_enable [*4] |-> !tx_enable) else $error("tx on without oscillator");
  chk_field_on: assert property (field_on_cmd && osc_reg_enable |-> ##[1:6] tx_enable)
    else $error("field-on did not enable tx");
  chk_ramp_len: assert property ($fell(tx_slow_ramping) && tx_enable |-> ramp_cnt >= RAMP_CYC)
    else $error("slow ramp too short");
endmodule : iocr_assertions

bind iocr_regs iocr_assertions #(.RAMP_CYC(RAMP_CYC)) u_chk (.*);

// ---- iocr_host_pins.sv ----
// host side pin model: select and data-out drive, changed just after a clock edge
`timescale 1ns/1ps
module iocr_host_pins (
  input  wire logic core_clk,
  input  wire logic sel,
  input  wire logic drv,
  output logic      slave_select_n,
  output logic      data_out_driven
);
  // deselected at time zero; drive only counts while selected
  initial {slave_select_n, data_out_driven} = 2'b10;
  always @(posedge core_clk) begin
    slave_select_n  <= ~sel;
    data_out_driven <= sel & drv;
  end
endmodule : iocr_host_pins

// ---- io_and_operation_control_regs_tb.sv ----
// self-checking bench of the io and operation control register bank
`timescale 1ns/1ps
module io_and_operation_control_regs_tb;
  import iocr_pkg::*;
  localparam int RAMP_CYC = 4;
  logic core_clk = 0, reset = 1, field_on_cmd = 0, active_peer_mode = 0, tx_finished = 0, auto_ch_amplitude = 0;
  logic sel = 0, drv = 0, slave_select_n, data_out_driven, low_supply_select, digital_supply_rail_off;
  logic data_out_pulldown, data_out_boost, osc_reg_enable, rx_enable, rx_amp_ch_on, rx_phase_ch_on;
  logic rx_use_amplitude, tx_enable, tx_slow_ramping, wakeup_mode_on;
  iocr_req_t   avs_req = '0;
  iocr_rsp_t   avs_rsp;
  int          n_fail = 0, num_checks = 0, io_m = 0, op_m = 0, pk_m = 0, cnt;
  logic [31:0] seed = 32'h2b, rd, d;
  logic [1:0]  rs;
  iocr_regs #(.RAMP_CYC(RAMP_CYC)) u_dut (.*);
  iocr_host_pins u_host (.*);
  always #50 core_clk = ~core_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  // one avalon access; request held until waitrequest is seen low
  task automatic bus(logic wr, logic [3:0] a, logic [7:0] v);
    int n;
    @(posedge core_clk);
    avs_req <= '{a, !wr, wr, {24'h0, v}, 4'hf};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_rsp.waitrequest && n < 50);
    if (n >= 50) n_fail++;
    rd = avs_rsp.readdata;
    rs = avs_rsp.response;
    avs_req <= '0;
  endtask : bus
  task automatic rdchk(string nm, logic [3:0] a, int exp);
    bus(0, a, 0);
    chk(nm, exp, rd);
  endtask : rdchk
  // outputs against the model once the registered outputs settled
  task automatic outs();
    bit en, one, pk;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    en = op_m[7];
    one = op_m[5];
    pk = pk_m[0];
    chk("supply", io_m[7], low_supply_select);
    chk("regoff", io_m[6], digital_supply_rail_off);
    chk("boost", io_m[2], data_out_boost);
    chk("osc", en, osc_reg_enable);
    chk("rx", en & op_m[6], rx_enable);
    chk("wakeup", op_m[2], wakeup_mode_on);
    chk("pulldown", (io_m[4] & sel & !drv) | (io_m[3] & !sel), data_out_pulldown);
    if (en & op_m[6]) begin
      chk("amp", !(one & pk), rx_amp_ch_on);
      chk("phase", !one | pk, rx_phase_ch_on);
      chk("useamp", (one | op_m[4]) ? !pk : auto_ch_amplitude, rx_use_amplitude);
    end
  endtask : outs
  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // watchdog well beyond the expected run of about 420 cycles
  initial begin
    #(5000 * 100);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 0;
    rdchk("io_rst", 4'h1, 0);
    rdchk("op_rst", 4'h2, 0);
    outs();
    bus(1, 4'h5, 8'hff);
    chk("unmap_rd", 0, rd);
    chk("unmap_rsp", 2, rs);
    bus(0, 4'h5, 8'h00);
    chk("unmap_rd2", 0, rd);
    chk("unmap_rsp2", 2, rs);
    // random settings, rx enable bit kept set so channel choice shows whenever bit 7 is set
    for (int i = 0; i < 12; i++) begin
      d = xs();
      bus(1, 4'h1, d[7:0]);
      io_m = d[7:0] & 8'hdd;
      bus(1, 4'h2, d[15:8] | 8'h40);
      op_m = (d[15:8] | 8'h40) & 8'hfc;
      bus(1, 4'ha, d[23:16]);
      pk_m = d[16];
      auto_ch_amplitude <= d[24];
      rdchk("io_rb", 4'h1, io_m);
      rdchk("op_rb", 4'h2, op_m);
      outs();
    end
    // every pull-down setting against every pin state
    for (int i = 0; i < 16; i++) begin
      sel <= i[1];
      drv <= i[0];
      io_m = {i[3:2], 3'b0};
      bus(1, 4'h1, io_m[7:0]);
      outs();
    end
    bus(1, 4'h1, 8'h00);
    bus(1, 4'h2, 8'h80);
    @(posedge core_clk);
    field_on_cmd <= 1;
    @(posedge core_clk);
    field_on_cmd <= 0;
    rdchk("fieldon", 4'h2, 8'h88);
    chk("tx_on", 1, tx_enable);
    chk("fast", 0, tx_slow_ramping);
    tx_finished <= 1;
    @(posedge core_clk);
    tx_finished <= 0;
    rdchk("no_peer", 4'h2, 8'h88);
    active_peer_mode <= 1;
    tx_finished <= 1;
    @(posedge core_clk);
    tx_finished <= 0;
    rdchk("peer_clr", 4'h2, 8'h80);
    repeat (4) @(posedge core_clk);
    chk("tx_off", 0, tx_enable);
    bus(1, 4'h1, 8'h01);
    bus(1, 4'h2, 8'h88);
    cnt = 0;
    repeat (20) begin
      @(negedge core_clk);
      cnt += tx_slow_ramping;
    end
    chk("ramp", RAMP_CYC, cnt);
    chk("tx_full", 1, tx_enable);
    rdchk("status", 4'hb, 8'h07);
    tally_and_finish();
  end
endmodule : io_and_operation_control_regs_tb
